//--- logic/piof_pin_io_and_event_flags.sv
// Pin I/O and event flag block: three pins, fourth flag/enable pair, serial slave.
// Assumes all inputs synchronous to clk and event inputs one-cycle pulses.
//
// Notes on behaviour
// - Set tx delimiter flag, bit 7, on pulse
// - Set rx delimiter flag within one microsecond
// - Host read clears delimiter and measure flags
// - Set malfunction flag, bit 5, on fault
// - Warning on low supply or resistor fault
// - Measurement start bit cleared, done flag set
// - Pin flag only in normal enabled input
// - Direction bit clear means output pin
// - All pins inputs after power-on reset
// - Hysteresis bit selects Schmitt input buffer
// - Value bits read levels, write drive levels
// - Pull enable bit turns weak pull on
// - Pull direction set up, clear down
// - Pin enable bit gates its interrupt, not its flag
// - Interrupt pin driven only with global enable
// - Polarity set rising, clear falling edge
// - Frequency offset captured with rx delimiter
// - Pull disabled while pin is output
// - Other modes drive pins with internal states
`default_nettype none

module piof_pin_io_and_event_flags #(
  parameter int PIN_COUNT = 3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic irq_n,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  output logic [2:0] pin_hysteresis_enable,
  output logic [2:0] pin_pull_enable,
  output logic [2:0] pin_pull_direction,
  input wire piof_pkg::piof_events_t events,
  input wire logic [4:0] supply_level,
  input wire logic [4:0] battery_threshold,
  input wire logic [7:0] freq_offset_measure,
  input wire logic [2:0] monitor_state,
  output logic energy_detect_start,
  output logic channel_assess_start,
  output logic [7:0] freq_offset_value
);

  // ==========================================================
  // Elaboration check
  if (PIN_COUNT != 3) begin : g_bad_pins
    $error("PIN_COUNT must be 3 to fit the register layout");
  end

  // ==========================================================
  // State
  piof_pkg::piof_state_t st_reg;
  piof_pkg::piof_state_t st_next;

  logic [2:0] pin_level;
  logic [7:0] read_data;
  logic [6:0] rd_addr;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [2:0] edge_hit;
  logic normal_gpio;
  logic batt_low;
  logic sck_rise;
  logic sck_fall;
  logic addr_done;
  logic data_done;

  // ==========================================================
  // Pin level seen by the host: inputs sample pad, outputs echo drive
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_level[i] = st_reg.pad.drive_en[i] ? st_reg.pad.drive[i] : pin_in[i];
    end
  end

  // Read data mux, addressed by the byte just completed
  always_comb begin
    read_data = piof_pkg::UNMAPPED_READ;
    case (rd_addr)
      piof_pkg::EVENT_FLAGS_ADDR: read_data = st_reg.flags;
      piof_pkg::EVENT_ENABLES_ADDR: read_data = st_reg.enables;
      piof_pkg::PIN_CONFIG_ADDR: begin
        read_data[piof_pkg::GIE_BIT] = st_reg.global_irq_enable;
        read_data[piof_pkg::IRQ_PENDING_BIT] = ~st_reg.irq_n;
        read_data[piof_pkg::MODE_LSB +: 4] = st_reg.mode;
      end
      piof_pkg::PIN_DIR_VALUE_ADDR: begin
        read_data[piof_pkg::PIN_FUNC_EN_BIT] = st_reg.pin_func_en;
        read_data[piof_pkg::UPPER_FIELD_LSB +: 3] = st_reg.direction;
        read_data[piof_pkg::LOWER_FIELD_LSB +: 3] = pin_level;
      end
      piof_pkg::PIN_POL_HYST_ADDR: begin
        read_data[piof_pkg::UPPER_FIELD_LSB +: 3] = st_reg.polarity;
        read_data[piof_pkg::LOWER_FIELD_LSB +: 3] = st_reg.hysteresis;
      end
      piof_pkg::PIN_PULL_ADDR: begin
        read_data[piof_pkg::UPPER_FIELD_LSB +: 3] = st_reg.pull_direction;
        read_data[piof_pkg::LOWER_FIELD_LSB +: 3] = st_reg.pull_enable;
      end
      piof_pkg::MEASURE_CTRL_ADDR: read_data[1:0] = st_reg.measure_start;
      piof_pkg::FREQ_OFFSET_ADDR: read_data = st_reg.freq_offset;
      default: read_data = piof_pkg::UNMAPPED_READ;
    endcase
  end

  // Event detection
  always_comb begin
    normal_gpio = (st_reg.mode == piof_pkg::MODE_NORMAL) && st_reg.pin_func_en;
    batt_low = supply_level < battery_threshold;
    for (int i = 0; i < 3; i++) begin
      // Rising when polarity set, falling otherwise
      edge_hit[i] = st_reg.polarity[i] ? (pin_in[i] & ~st_reg.pin_prev[i])
                                       : (~pin_in[i] & st_reg.pin_prev[i]);
    end
    flag_set = 8'h00;
    flag_set[piof_pkg::TX_DELIM_BIT] = events.tx_delim_sent;
    flag_set[piof_pkg::RX_DELIM_BIT] = events.rx_delim_seen;
    flag_set[piof_pkg::MALFUNCTION_BIT] = events.malfunction;
    flag_set[piof_pkg::WARNING_BIT] = (batt_low & ~st_reg.batt_low_prev)
                                      | events.resistor_fault;
    flag_set[piof_pkg::MEASURE_DONE_BIT] = events.measure_complete
                                           & (|st_reg.measure_start);
    flag_set[piof_pkg::PIN_EVENT_LSB +: 3] = edge_hit & st_reg.direction
                                             & {3{normal_gpio}};
  end

  // Serial edge strobes
  always_comb begin
    sck_rise = spi_sck & ~st_reg.sck_prev & ~spi_cs_n;
    sck_fall = ~spi_sck & st_reg.sck_prev & ~spi_cs_n;
    addr_done = sck_rise && st_reg.phase == piof_pkg::PIOF_SPI_ADDR
                && st_reg.bit_cnt == piof_pkg::SPI_BYTE_LAST;
    data_done = sck_rise && st_reg.phase == piof_pkg::PIOF_SPI_DATA
                && st_reg.bit_cnt == piof_pkg::SPI_BYTE_LAST;
    // Address not yet latched at the last address rise, so take it from the shifter
    rd_addr = addr_done ? {st_reg.shift_in[5:0], spi_mosi} : st_reg.addr;
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.sck_prev = spi_sck;
    st_next.pin_prev = pin_in;
    st_next.batt_low_prev = batt_low;
    flag_clr = 8'h00;

    // Serial frame: byte 0 is read bit and address, byte 1 is data
    case (st_reg.phase)
      piof_pkg::PIOF_SPI_IDLE: begin
        st_next.bit_cnt = 4'h0;
        if (!spi_cs_n) begin
          st_next.phase = piof_pkg::PIOF_SPI_ADDR;
        end
      end
      piof_pkg::PIOF_SPI_ADDR: begin
        if (sck_rise) begin
          st_next.shift_in = {st_reg.shift_in[6:0], spi_mosi};
          st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
        end
        if (addr_done) begin
          st_next.rd = st_reg.shift_in[6];
          st_next.addr = {st_reg.shift_in[5:0], spi_mosi};
          st_next.bit_cnt = 4'h0;
          st_next.phase = piof_pkg::PIOF_SPI_DATA;
        end
      end
      piof_pkg::PIOF_SPI_DATA: begin
        if (sck_rise) begin
          st_next.shift_in = {st_reg.shift_in[6:0], spi_mosi};
          st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
        end
        if (sck_fall) begin
          st_next.miso = st_reg.shift_out[7];
          st_next.shift_out = {st_reg.shift_out[6:0], 1'b0};
        end
        if (data_done) begin
          st_next.bit_cnt = 4'h0;
        end
      end
      default: st_next.phase = piof_pkg::PIOF_SPI_IDLE;
    endcase
    if (spi_cs_n) begin
      st_next.phase = piof_pkg::PIOF_SPI_IDLE;
      st_next.miso = 1'b0;
    end

    // Read data loaded as the address byte completes, before any read clear
    if (addr_done) begin
      st_next.shift_out = st_reg.shift_in[6] ? read_data : 8'h00;
    end

    // Register writes
    if (data_done && !st_reg.rd) begin
      case (st_reg.addr)
        piof_pkg::EVENT_FLAGS_ADDR: begin
          flag_clr = piof_pkg::WRITE_CLEAR_MASK & ~{st_reg.shift_in[6:0], spi_mosi};
        end
        piof_pkg::EVENT_ENABLES_ADDR: st_next.enables = {st_reg.shift_in[6:0], spi_mosi};
        piof_pkg::PIN_CONFIG_ADDR: begin
          st_next.global_irq_enable = st_reg.shift_in[piof_pkg::GIE_BIT - 1];
          st_next.mode = {st_reg.shift_in[2:0], spi_mosi};
        end
        piof_pkg::PIN_DIR_VALUE_ADDR: begin
          st_next.pin_func_en = st_reg.shift_in[6];
          st_next.direction = st_reg.shift_in[5:3];
          st_next.out_value = {st_reg.shift_in[1:0], spi_mosi};
        end
        piof_pkg::PIN_POL_HYST_ADDR: begin
          st_next.polarity = st_reg.shift_in[5:3];
          st_next.hysteresis = {st_reg.shift_in[1:0], spi_mosi};
        end
        piof_pkg::PIN_PULL_ADDR: begin
          st_next.pull_direction = st_reg.shift_in[5:3];
          st_next.pull_enable = {st_reg.shift_in[1:0], spi_mosi};
        end
        piof_pkg::MEASURE_CTRL_ADDR: st_next.measure_start = {st_reg.shift_in[0], spi_mosi};
        default: st_next.enables = st_reg.enables;
      endcase
    end

    // Flags: host read of the flag register clears, a new event wins
    if (addr_done && st_reg.shift_in[6]
        && {st_reg.shift_in[5:0], spi_mosi} == piof_pkg::EVENT_FLAGS_ADDR) begin
      flag_clr = piof_pkg::READ_CLEAR_MASK;
    end
    st_next.flags = (st_reg.flags & ~flag_clr) | flag_set;

    // Measurement start cleared on completion
    if (events.measure_complete) begin
      st_next.measure_start = 2'b00;
    end

    // Offset measurement latched with the rx delimiter event
    if (events.rx_delim_seen) begin
      st_next.freq_offset = freq_offset_measure;
    end

    // Interrupt output
    st_next.irq_n = ~(st_next.global_irq_enable & |(st_next.flags & st_next.enables));

    // Pad controls
    if (st_next.mode != piof_pkg::MODE_NORMAL) begin
      st_next.pad.drive = monitor_state;
      st_next.pad.drive_en = 3'h7;
    end else if (st_next.pin_func_en) begin
      st_next.pad.drive = st_next.out_value;
      st_next.pad.drive_en = ~st_next.direction;
    end else begin
      st_next.pad.drive = 3'h0;
      st_next.pad.drive_en = 3'h0;
    end
    st_next.pad.hysteresis_en = st_next.hysteresis;
    st_next.pad.pull_en = st_next.pull_enable & ~st_next.pad.drive_en;
    st_next.pad.pull_up = st_next.pull_direction;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.phase <= piof_pkg::PIOF_SPI_IDLE;
      st_reg.sck_prev <= 1'b0;
      st_reg.flags <= piof_pkg::EVENT_FLAGS_RESET;
      st_reg.enables <= piof_pkg::EVENT_ENABLES_RESET;
      st_reg.global_irq_enable <= piof_pkg::GIE_RESET;
      st_reg.mode <= piof_pkg::MODE_RESET;
      st_reg.direction <= piof_pkg::DIRECTION_RESET;
      st_reg.out_value <= piof_pkg::FIELD3_RESET;
      st_reg.polarity <= piof_pkg::FIELD3_RESET;
      st_reg.hysteresis <= piof_pkg::FIELD3_RESET;
      st_reg.pull_enable <= piof_pkg::FIELD3_RESET;
      st_reg.pull_direction <= piof_pkg::FIELD3_RESET;
      st_reg.irq_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs straight from state flops
  assign spi_miso = st_reg.miso;
  assign irq_n = st_reg.irq_n;
  assign pin_out = st_reg.pad.drive;
  assign pin_oe = st_reg.pad.drive_en;
  assign pin_hysteresis_enable = st_reg.pad.hysteresis_en;
  assign pin_pull_enable = st_reg.pad.pull_en;
  assign pin_pull_direction = st_reg.pad.pull_up;
  assign energy_detect_start = st_reg.measure_start[0];
  assign channel_assess_start = st_reg.measure_start[1];
  assign freq_offset_value = st_reg.freq_offset;

endmodule

`default_nettype wire

//--- logic/piof_pkg.sv
// Package for the pin I/O and event flag block: offsets, fields, resets.
// Assumes a single 25 MHz core clock and a host on a four-wire serial port.
`default_nettype none

package piof_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [6:0] EVENT_FLAGS_ADDR = 7'h07;
  localparam logic [6:0] EVENT_ENABLES_ADDR = 7'h0b;
  localparam logic [6:0] PIN_CONFIG_ADDR = 7'h0c;
  localparam logic [6:0] PIN_DIR_VALUE_ADDR = 7'h0d;
  localparam logic [6:0] PIN_POL_HYST_ADDR = 7'h0e;
  localparam logic [6:0] PIN_PULL_ADDR = 7'h0f;
  localparam logic [6:0] MEASURE_CTRL_ADDR = 7'h10;
  localparam logic [6:0] FREQ_OFFSET_ADDR = 7'h11;

  // ==========================================================
  // Event flag bit positions
  localparam int TX_DELIM_BIT = 7;
  localparam int RX_DELIM_BIT = 6;
  localparam int MALFUNCTION_BIT = 5;
  localparam int WARNING_BIT = 4;
  localparam int MEASURE_DONE_BIT = 3;
  localparam int PIN_EVENT_LSB = 0;
  // Bits cleared by a host read of the flag register
  localparam logic [7:0] READ_CLEAR_MASK = 8'hcf;
  // Bits the host may clear by writing zero
  localparam logic [7:0] WRITE_CLEAR_MASK = 8'h30;

  // ==========================================================
  // Field positions
  localparam int GIE_BIT = 6;
  localparam int IRQ_PENDING_BIT = 4;
  localparam int MODE_LSB = 0;
  localparam int PIN_FUNC_EN_BIT = 7;
  localparam int UPPER_FIELD_LSB = 4;
  localparam int LOWER_FIELD_LSB = 0;
  localparam logic [3:0] MODE_NORMAL = 4'h0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] EVENT_FLAGS_RESET = 8'h00;
  localparam logic [7:0] EVENT_ENABLES_RESET = 8'h38;
  localparam logic GIE_RESET = 1'b1;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [2:0] DIRECTION_RESET = 3'h7;
  localparam logic [2:0] FIELD3_RESET = 3'h0;

  // ==========================================================
  // Serial port framing
  localparam logic [3:0] SPI_BYTE_LAST = 4'h7;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  typedef enum logic [1:0] {
    PIOF_SPI_IDLE = 2'b00,
    PIOF_SPI_ADDR = 2'b01,
    PIOF_SPI_DATA = 2'b11
  } piof_spi_phase_t;

  // Event pulses from the radio units
  typedef struct packed {
    logic tx_delim_sent;
    logic rx_delim_seen;
    logic malfunction;
    logic resistor_fault;
    logic measure_complete;
  } piof_events_t;

  // Pad controls per pin
  typedef struct packed {
    logic [2:0] drive;
    logic [2:0] drive_en;
    logic [2:0] hysteresis_en;
    logic [2:0] pull_en;
    logic [2:0] pull_up;
  } piof_pad_ctrl_t;

  // Whole block state
  typedef struct packed {
    piof_spi_phase_t phase;
    logic [3:0] bit_cnt;
    logic rd;
    logic [6:0] addr;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic miso;
    logic sck_prev;
    logic [7:0] flags;
    logic [7:0] enables;
    logic global_irq_enable;
    logic [3:0] mode;
    logic pin_func_en;
    logic [2:0] direction;
    logic [2:0] out_value;
    logic [2:0] polarity;
    logic [2:0] hysteresis;
    logic [2:0] pull_enable;
    logic [2:0] pull_direction;
    logic [1:0] measure_start;
    logic [7:0] freq_offset;
    logic [2:0] pin_prev;
    logic batt_low_prev;
    logic irq_n;
    piof_pad_ctrl_t pad;
  } piof_state_t;

endpackage

`default_nettype wire

//--- verification/piof_assertions.sv
// Checker of the pin and event flag block, on its ports only.
// Assumes one clock domain; bound to the block at the foot of this file.
`default_nettype none

module piof_assertions (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_miso,
  input wire logic irq_n,
  input wire logic [2:0] pin_oe,
  input wire logic [2:0] pin_pull_enable,
  input wire piof_pkg::piof_events_t events,
  input wire logic [7:0] freq_offset_measure,
  input wire logic energy_detect_start,
  input wire logic [7:0] freq_offset_value
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ==========================================
  // Frame sequences
  sequence s_idle;
    spi_cs_n [*2];
  endsequence
  sequence s_sck_high;
    spi_sck [*3];
  endsequence

  // ==========================================
  // Properties
  property p_reset_inputs;
    disable iff (1'b0) sys_rst |-> pin_oe == 3'h0 && pin_pull_enable == 3'h0;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("pins not inputs");
  property p_pull_off;
    (pin_pull_enable & pin_oe) == 3'h0;
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("pull on output");
  property p_oe_cause;
    $changed(pin_oe) |-> $past(!spi_cs_n);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("direction moved alone");
  property p_miso_idle;
    s_idle |-> !spi_miso;
  endproperty
  a_miso_idle: assert property (p_miso_idle) else $error("miso driven idle");
  property p_miso_steady;
    s_sck_high |-> $stable(spi_miso);
  endproperty
  a_miso_steady: assert property (p_miso_steady) else $error("miso moved");
  property p_measure_clear;
    events.measure_complete && energy_detect_start |=> !energy_detect_start;
  endproperty
  a_measure_clear: assert property (p_measure_clear) else $error("start kept");
  property p_offset_capture;
    events.rx_delim_seen |=> freq_offset_value == $past(freq_offset_measure);
  endproperty
  a_offset_capture: assert property (p_offset_capture) else $error("offset");
  property p_irq_release;
    $rose(irq_n) |-> $past(!spi_cs_n);
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("irq released");
endmodule

bind piof_pin_io_and_event_flags piof_assertions chk_u (
  .clk(clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
  .spi_miso(spi_miso), .irq_n(irq_n), .pin_oe(pin_oe), .pin_pull_enable(pin_pull_enable),
  .events(events), .freq_offset_measure(freq_offset_measure),
  .energy_detect_start(energy_detect_start), .freq_offset_value(freq_offset_value)
);

`default_nettype wire

//--- verification/piof_host_model.sv
// Host model: sends one command byte and one data byte per frame.
// Assumes the bench clock; serial clock half period is four clk cycles.
`default_nettype none

module piof_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================
  // Frame, MSB first; read data taken at the rises of the second byte
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rdata);
    logic [15:0] sh;
    sh = {cmd, wd};
    rdata = 8'h00;
    @(posedge clk);
    #1 cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = sh[i];
      repeat (4) @(posedge clk);
      #1 sck = 1'b1;
      if (i < 8) begin
        rdata = {rdata[6:0], miso};
      end
      repeat (4) @(posedge clk);
      #1 sck = 1'b0;
    end
    repeat (4) @(posedge clk);
    #1 cs_n = 1'b1;
    mosi = ~mosi; // Idle line shows no stale bit
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Idle lines at time zero; clock stands low between frames
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
endmodule

`default_nettype wire

//--- verification/piof_pin_io_and_event_flags_tb_top.sv
// Bench for the pin and event flag block: registers, pins, events.
// Assumes the host model for frames and the bound checker.
`default_nettype none

module piof_pin_io_and_event_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic sys_rst;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic irq_n;
  logic [2:0] ext;
  logic [2:0] pin_in;
  logic [2:0] pin_out;
  logic [2:0] pin_oe;
  logic [2:0] hyst;
  logic [2:0] pull_en;
  logic [2:0] pull_dir;
  logic [4:0] ev_bits;
  logic [4:0] supply;
  logic [7:0] fom;
  logic [7:0] fov;
  logic eds;
  logic cas;
  int bad_count;
  int checked;
  int cyc;

  // Pads: a driven pin reads back its own level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

  // ==========================================
  // Block and host
  piof_pin_io_and_event_flags dut_u (
    .clk(clk), .sys_rst(sys_rst), .spi_cs_n(cs_n), .spi_sck(sck), .spi_mosi(mosi),
    .spi_miso(miso), .irq_n(irq_n), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_hysteresis_enable(hyst), .pin_pull_enable(pull_en), .pin_pull_direction(pull_dir),
    .events(piof_pkg::piof_events_t'(ev_bits)), .supply_level(supply),
    .battery_threshold(5'h10), .freq_offset_measure(fom), .monitor_state(3'h5),
    .energy_detect_start(eds), .channel_assess_start(cas), .freq_offset_value(fov));
  piof_host_model host_u (.clk(clk), .cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso));

  // ==========================================
  // Shared tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    host_u.xfer({1'b0, a}, d, r);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    host_u.xfer({1'b1, a}, 8'h00, d);
  endtask
  task automatic rdchk(input string w, input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(w, e, d);
  endtask
  task automatic pulse(input int i);
    ev_bits[i] = 1'b1;
    @(posedge clk);
    #1 ev_bits = 5'h00;
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_n !== 1'b0 && n < 25) begin
      @(posedge clk);
      #1 n++;
    end
    chk("irq_n low", 8'h00, {7'h0, irq_n});
  endtask
  task automatic pin_step(input logic [2:0] lv, input logic [7:0] fl, input logic ir);
    ext = lv;
    repeat (4) @(posedge clk);
    #1 chk("irq_n", {7'h0, ir}, {7'h0, irq_n});
    rdchk("pin flags", 7'h07, fl);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset();
    logic [6:0] ra [7] = '{7'h07, 7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h20};
    logic [7:0] rv [7] = '{8'h00, 8'h38, 8'h40, 8'h70, 8'h00, 8'h00, 8'h00};
    logic [7:0] d;
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], d);
      chk("reset value", rv[i], d & (ra[i] == 7'h0c ? 8'hef : 8'hff));
    end
    $display("t_reset done");
  endtask
  task automatic t_pins();
    ext = 3'h4;
    wr(7'h0d, 8'hc5);
    wr(7'h0f, 8'h57);
    wr(7'h0e, 8'h07);
    chk("pin_oe", 8'h03, {5'h0, pin_oe});
    chk("pin_out", 8'h01, {6'h0, pin_out[1:0]});
    chk("pull_en", 8'h04, {5'h0, pull_en});
    rdchk("levels", 7'h0d, 8'hc5);
    wr(7'h0d, 8'hf0);
    chk("pulls", 8'h57, {1'b0, pull_dir, 1'b0, pull_en});
    chk("hysteresis", 8'h07, {5'h0, hyst});
    $display("t_pins done");
  endtask
  task automatic t_pin_irq();
    logic [7:0] d;
    wr(7'h0e, 8'h50);
    wr(7'h0b, 8'h07);
    rd(7'h07, d);
    pin_step(3'h0, 8'h00, 1'b1);
    pin_step(3'h7, 8'h05, 1'b0);
    pin_step(3'h0, 8'h02, 1'b0);
    wr(7'h0b, 8'h02);
    pin_step(3'h7, 8'h05, 1'b1);
    wr(7'h0c, 8'h41);
    chk("monitor pins", 8'h3d, {2'h0, pin_oe, pin_out});
    pin_step(3'h0, 8'h00, 1'b1);
    wr(7'h0c, 8'h40);
    rd(7'h07, d);
    wr(7'h0d, 8'h70);
    pin_step(3'h7, 8'h00, 1'b1);
    $display("t_pin_irq done");
  endtask
  task automatic t_events();
    wr(7'h0b, 8'hf8);
    wr(7'h10, 8'h03);
    chk("start bits", 8'h03, {6'h0, eds, cas});
    fom = 8'h5a;
    for (int i = 4; i >= 0; i--) begin
      pulse(i);
      wait_irq();
      rdchk("event flag", 7'h07, 8'h08 << i);
      rdchk("flag reread", 7'h07, (i == 2 || i == 1) ? 8'h08 << i : 8'h00);
      wr(7'h07, 8'h00);
    end
    chk("start done", 8'h00, {6'h0, eds, cas});
    chk("offset", 8'h5a, fov);
    supply = 5'h0f;
    wr(7'h0c, 8'h00);
    chk("irq gated", 8'h01, {7'h0, irq_n});
    rdchk("low supply", 7'h07, 8'h10);
    wr(7'h0c, 8'h40);
    chk("irq open", 8'h00, {7'h0, irq_n});
    $display("t_events done");
  endtask

  task automatic print_verdict();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 20000) begin
        bad_count++;
        print_verdict();
      end
    end
  end

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    ev_bits = 5'h00;
    ext = 3'h0;
    supply = 5'h1f;
    fom = 8'h00;
    bad_count = 0;
    checked = 0;
    repeat (8) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_pins();
    t_pin_irq();
    t_events();
    print_verdict();
  end
endmodule

`default_nettype wire
